// [verilog/ccpcu_pkg.sv]
// Package with register map, field layout and mode codes of the capture/compare unit.
package ccpcu_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_VALUE_LOW = 8'h04;
  localparam logic [7:0] ADDR_VALUE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ADC_CTRL = 8'h10;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h3F;
  localparam int DUTY_LSB = 4;
  localparam int MODE_LSB = 0;
  localparam int STATUS_EVENT_BIT = 0;
  localparam int STATUS_LATCH_BIT = 1;
  localparam int ADC_ENABLE_BIT = 0;
  localparam logic [3:0] PRESCALE_16 = 4'hF;
  localparam logic [1:0] PRESCALE_4 = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    CCPCU_MODE_OFF = 4'h0,
    CCPCU_MODE_CAP_FALL = 4'h4,
    CCPCU_MODE_CAP_RISE = 4'h5,
    CCPCU_MODE_CAP_RISE4 = 4'h6,
    CCPCU_MODE_CAP_RISE16 = 4'h7,
    CCPCU_MODE_CMP_SET = 4'h8,
    CCPCU_MODE_CMP_CLR = 4'h9,
    CCPCU_MODE_CMP_SOFT = 4'hA,
    CCPCU_MODE_CMP_TRIG = 4'hB
  } ccpcu_mode_t;

  // Timebase view seen by the unit.
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } ccpcu_timebase_t;

  // Outputs towards the timebase and the converter.
  typedef struct packed {
    logic timebase_reset;
    logic adc_start;
  } ccpcu_trigger_t;
endpackage : ccpcu_pkg

// [verilog/ccpcu_sync.sv]
// Two-stage synchroniser for the module pin level.
module ccpcu_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_ff;
  logic nxt_stage1;
  logic stage2_ff;
  logic nxt_stage2;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_stage1 = async_in;
    nxt_stage2 = stage1_ff;
  end

  // Both stages clear on reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sync_out = stage2_ff;
endmodule : ccpcu_sync

// [verilog/ccpcu_prescaler.sv]
// Capture edge prescaler that counts rising edges of the module pin.
module ccpcu_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic rise,
  input wire logic [1:0] sel,
  output logic hit
);
  logic [3:0] count_ff;
  logic [3:0] nxt_count;

  // Selects which rising edge ends a prescale period.
  always_comb begin
    nxt_count = count_ff;
    hit = 1'b0;
    if (clear) begin
      nxt_count = 4'h0;
    end else if (rise) begin
      nxt_count = count_ff + 4'h1;
      unique case (sel)
        2'h0: hit = 1'b1;
        2'h1: hit = 1'b1;
        2'h2: hit = (count_ff[1:0] == ccpcu_pkg::PRESCALE_4);
        2'h3: hit = (count_ff == ccpcu_pkg::PRESCALE_16);
      endcase
    end
  end

  // A mode change without clear keeps the count running, which can give an early edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= 4'h0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule : ccpcu_prescaler

// [verilog/ccpcu_capture_compare_unit.sv]
// Capture/compare unit with its AHB-Lite register slave.
// Operation
// - Capture copies the 16-bit timebase count into the value registers.
// - Capture event: falling, rising, every 4th or 16th rising edge.
// - Each capture sets the event flag; software must clear it.
// - A new capture overwrites the stored value without any warning.
// - Edge detection watches the real pin level, even when driven.
// - Operation assured only with a synchronous timebase.
// - Prescaler clears when off, not capturing, or on reset.
// - Direct prescale changes keep the count; clear control first.
// - Compare checks the value registers against the timebase every cycle.
// - Every compare mode sets the event flag on a match.
// - Writing zero to control forces the compare latch low.
// - Mode 1010 only sets the flag and leaves the pin alone.
// - Mode 1011 resets the timebase and starts conversion if enabled.
// - Trigger asserts at match; timebase clears at the next tick.
// - Trigger resets never set the timebase overflow flag.
// - If the match vanishes before the tick, the reset is skipped.
// - Capture codes are 0100, 0101, 0110 and 0111.
// - Mode 1000 sets the output latch on a match.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
module ccpcu_capture_compare_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic module_pin_in,
  input wire ccpcu_pkg::ccpcu_timebase_t timebase,
  output ccpcu_pkg::ccpcu_trigger_t trigger,
  output logic module_pin_out,
  output logic module_pin_oe_n,
  output logic unit_event_flag,
  output logic timebase_overflow_block
);
  // Synchronised pin level and the sample before it.
  logic pin_sync;
  logic pin_prev_ff;
  logic nxt_pin_prev;

  // Software-visible registers: control, the value pair and the event flag.
  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic [15:0] value_ff;
  logic [15:0] nxt_value;
  logic event_ff;
  logic nxt_event;

  // Compare output latch; a zero control write forces it low.
  logic latch_ff;
  logic nxt_latch;

  // Converter enable, written by software.
  logic adc_enable_ff;
  logic nxt_adc_enable;

  // Match history and the timebase reset waiting for its tick.
  logic match_prev_ff;
  logic nxt_match_prev;
  logic trig_pend_ff;
  logic nxt_trig_pend;

  // Registered drives towards the timebase, the converter and the pin.
  logic tb_reset_ff;
  logic nxt_tb_reset;
  logic adc_start_ff;
  logic nxt_adc_start;
  logic pin_out_ff;
  logic nxt_pin_out;
  logic pin_oe_n_ff;
  logic nxt_pin_oe_n;

  // Bus state kept between the address phase and the data phase.
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Decoded mode and the events derived from the pin and the comparator.
  logic [3:0] mode;
  logic capturing;
  logic comparing;
  logic trig_mode;
  logic pin_owner;
  logic rise;
  logic fall;
  logic presc_hit;
  logic cap_event;
  logic match;
  logic match_rise;
  logic bus_take;

  // Decodes whether a mode code selects one of the capture modes.
  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m[3:2] == 2'h1);
  endfunction : is_capture

  // Decodes whether a mode code selects one of the compare modes.
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m[3:2] == 2'h2);
  endfunction : is_compare

  // Decodes the special event trigger mode, used by both the trigger and its cancel.
  function automatic logic is_trigger(input logic [3:0] m);
    is_trigger = (m == ccpcu_pkg::CCPCU_MODE_CMP_TRIG);
  endfunction : is_trigger

  // Decodes the modes in which the compare latch owns the module pin.
  function automatic logic is_pin_owner(input logic [3:0] m);
    is_pin_owner = (m == ccpcu_pkg::CCPCU_MODE_CMP_SET) ||
                   (m == ccpcu_pkg::CCPCU_MODE_CMP_CLR);
  endfunction : is_pin_owner

  // The pin is sampled as driven, so a port write while it is an output can capture.
  ccpcu_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(module_pin_in),
    .sync_out(pin_sync)
  );

  // Only rising edges are counted; the falling-edge mode bypasses the prescaler.
  ccpcu_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!capturing),
    .rise(rise),
    .sel(mode[1:0]),
    .hit(presc_hit)
  );

  // Mode decoding, edge detection and the continuous comparator.
  // Everything here settles within one cycle of a control write.
  always_comb begin
    mode = control_ff[ccpcu_pkg::MODE_LSB +: 4];
    capturing = is_capture(mode);
    comparing = is_compare(mode);
    trig_mode = is_trigger(mode);
    pin_owner = is_pin_owner(mode);
    // A rise or fall is a change between two synchronised samples.
    nxt_pin_prev = pin_sync;
    rise = pin_sync && !pin_prev_ff;
    fall = !pin_sync && pin_prev_ff;
    cap_event = capturing && ((mode == ccpcu_pkg::CCPCU_MODE_CAP_FALL) ? fall : presc_hit);
    // The timebase shares hclk; an asynchronous counter could be caught in mid-change.
    match = comparing && (value_ff == timebase.count);
    // A lasting match sets the flag only once, on its first cycle.
    match_rise = match && !match_prev_ff;
    nxt_match_prev = match;
    // Transfers are taken only while the bus is ready; hsize is ignored, all are words.
    bus_take = hsel && hready && (htrans == ccpcu_pkg::HTRANS_NONSEQ);
  end

  // Bus side: one wait-free data phase; reads are registered at the address phase.
  // Writes need their data phase, so only the address and the direction are kept here.
  always_comb begin
    nxt_wr_pend = bus_take && hwrite;
    nxt_wr_addr = haddr;
    nxt_rdata = rdata_ff;
    if (bus_take && !hwrite) begin
      unique case (haddr)
        ccpcu_pkg::ADDR_CONTROL: nxt_rdata = {24'h000000, control_ff};
        ccpcu_pkg::ADDR_VALUE_LOW: nxt_rdata = {24'h000000, value_ff[7:0]};
        ccpcu_pkg::ADDR_VALUE_HIGH: nxt_rdata = {24'h000000, value_ff[15:8]};
        ccpcu_pkg::ADDR_STATUS: nxt_rdata = {30'h00000000, latch_ff, event_ff};
        ccpcu_pkg::ADDR_ADC_CTRL: nxt_rdata = {31'h00000000, adc_enable_ff};
        // Unmapped offsets read as zero.
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // Register updates; hardware set of the flag wins over a software clear.
  // The value pair is written a byte at a time, so a match can be seen in between.
  always_comb begin
    nxt_control = control_ff;
    nxt_value = value_ff;
    nxt_event = event_ff;
    nxt_adc_enable = adc_enable_ff;
    if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        // Bits 7-6 are not implemented and always read zero.
        ccpcu_pkg::ADDR_CONTROL: nxt_control = hwdata[7:0] & ccpcu_pkg::CONTROL_WMASK;
        ccpcu_pkg::ADDR_VALUE_LOW: nxt_value[7:0] = hwdata[7:0];
        ccpcu_pkg::ADDR_VALUE_HIGH: nxt_value[15:8] = hwdata[7:0];
        ccpcu_pkg::ADDR_STATUS: begin
          // Writing one leaves the flag alone, so a read-modify-write cannot set it.
          if (!hwdata[ccpcu_pkg::STATUS_EVENT_BIT]) begin
            nxt_event = 1'b0;
          end
        end
        ccpcu_pkg::ADDR_ADC_CTRL: nxt_adc_enable = hwdata[ccpcu_pkg::ADC_ENABLE_BIT];
        default: nxt_event = event_ff;
      endcase
    end
    // Hardware sets come after the bus write so that they win in a shared cycle.
    if (cap_event) begin
      nxt_value = timebase.count;
      nxt_event = 1'b1;
    end
    if (match_rise) begin
      nxt_event = 1'b1;
    end
  end

  // Compare latch, trigger and pin drive.
  always_comb begin
    nxt_latch = latch_ff;
    nxt_trig_pend = trig_pend_ff;
    nxt_tb_reset = 1'b0;
    nxt_adc_start = 1'b0;
    // Set and clear act on the first cycle of a match only, like the flag.
    if (match_rise && (mode == ccpcu_pkg::CCPCU_MODE_CMP_SET)) begin
      nxt_latch = 1'b1;
    end
    if (match_rise && (mode == ccpcu_pkg::CCPCU_MODE_CMP_CLR)) begin
      nxt_latch = 1'b0;
    end
    // A write of exactly zero to control wins over a match in the same cycle and returns the latch low.
    if (wr_pend_ff && (wr_addr_ff == ccpcu_pkg::ADDR_CONTROL) && (hwdata[7:0] == 8'h00)) begin
      nxt_latch = 1'b0;
    end
    // The converter start is a one-cycle pulse, registered one edge after the match.
    if (match_rise && trig_mode) begin
      nxt_trig_pend = 1'b1;
      nxt_adc_start = adc_enable_ff;
    end
    // A rewritten value that breaks the match before the tick cancels the timebase reset.
    if (trig_pend_ff && !(match && trig_mode)) begin
      nxt_trig_pend = 1'b0;
    end else if (trig_pend_ff && timebase.tick) begin
      nxt_tb_reset = 1'b1;
      nxt_trig_pend = 1'b0;
    end
    // Only set and clear modes own the pin; the rest leave it to the port.
    nxt_pin_out = latch_ff;
    nxt_pin_oe_n = !pin_owner;
  end

  // All state of the unit clears on reset except pin_oe_n_ff, which sets.
  // The pin driver starts released so that the port keeps the pin after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_ff <= 1'b0;
      control_ff <= ccpcu_pkg::CONTROL_RESET;
      value_ff <= 16'h0000;
      event_ff <= 1'b0;
      latch_ff <= 1'b0;
      adc_enable_ff <= 1'b0;
      match_prev_ff <= 1'b0;
      trig_pend_ff <= 1'b0;
      tb_reset_ff <= 1'b0;
      adc_start_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
      control_ff <= nxt_control;
      value_ff <= nxt_value;
      event_ff <= nxt_event;
      latch_ff <= nxt_latch;
      adc_enable_ff <= nxt_adc_enable;
      match_prev_ff <= nxt_match_prev;
      trig_pend_ff <= nxt_trig_pend;
      tb_reset_ff <= nxt_tb_reset;
      adc_start_ff <= nxt_adc_start;
      pin_out_ff <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flip-flops; the bus never waits and never errs.
  // A timebase reset from the trigger must not raise overflow, so the timer is told to block it.
  always_comb begin
    hrdata = rdata_ff;
    hreadyout = 1'b1;
    hresp = 1'b0;
    trigger.timebase_reset = tb_reset_ff;
    trigger.adc_start = adc_start_ff;
    module_pin_out = pin_out_ff;
    module_pin_oe_n = pin_oe_n_ff;
    unit_event_flag = event_ff;
    timebase_overflow_block = tb_reset_ff;
  end
endmodule : ccpcu_capture_compare_unit

// [tb/ccpcu_pin_source.sv]
// Event source model that drives bursts of pulses onto the module pin.
module ccpcu_pin_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [4:0] npul,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left_ff;
  logic [1:0] ph_ff;
  logic pin_ff;
  // Each pulse is two cycles high then two low, long enough for the pin synchroniser.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_ff <= 5'h0;
      ph_ff <= 2'h0;
      pin_ff <= 1'b0;
    end else if (go) begin
      left_ff <= npul;
      ph_ff <= 2'h0;
    end else if (left_ff != 5'h0) begin
      ph_ff <= ph_ff + 2'h1;
      pin_ff <= ~ph_ff[1];
      left_ff <= left_ff - ((ph_ff == 2'h3) ? 5'h1 : 5'h0);
    end
  end
  assign pin = pin_ff;
  assign busy = left_ff != 5'h0;
endmodule : ccpcu_pin_source

// [tb/ccpcu_props_properties.sv]
// Checker with the port timing relations of the capture/compare unit.
module ccpcu_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ccpcu_pkg::ccpcu_timebase_t timebase,
  input wire ccpcu_pkg::ccpcu_trigger_t trigger,
  input wire logic module_pin_out,
  input wire logic module_pin_oe_n,
  input wire logic unit_event_flag,
  input wire logic timebase_overflow_block
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic nxt_ctl_wr;
  logic nxt_st_wr;
  logic ctl_wr_ff;
  logic st_wr_ff;
  // Address-phase writes are remembered so data-phase effects can be tied to them.
  assign take = hsel && hready && htrans == ccpcu_pkg::HTRANS_NONSEQ && hwrite;
  assign nxt_ctl_wr = take && haddr == ccpcu_pkg::ADDR_CONTROL;
  assign nxt_st_wr = take && haddr == ccpcu_pkg::ADDR_STATUS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_wr_ff <= 1'b0;
      st_wr_ff <= 1'b0;
    end else begin
      ctl_wr_ff <= nxt_ctl_wr;
      st_wr_ff <= nxt_st_wr;
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_zero_write;
    ctl_wr_ff && hwdata == 32'h0;
  endsequence
  // Latch and pin driver need up to three edges to settle after the write lands.
  sequence s_pin_released;
    ##3 (!module_pin_out && module_pin_oe_n);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_ovf_block: assert property (timebase_overflow_block == trigger.timebase_reset)
    else $error("overflow block differs from timer reset");
  chk_reset_tick: assert property (trigger.timebase_reset |-> $past(timebase.tick))
    else $error("timer reset without preceding tick");
  chk_adc_single: assert property (trigger.adc_start |=> !trigger.adc_start)
    else $error("conversion start longer than one cycle");
  chk_trig_no_pin: assert property (trigger.adc_start |-> module_pin_oe_n)
    else $error("pin driven in trigger mode");
  chk_flag_sticky: assert property ($fell(unit_event_flag) |-> $past(st_wr_ff))
    else $error("event flag fell without status write");
  chk_zero_latch: assert property (s_zero_write |-> s_pin_released)
    else $error("zero control left latch or driver on");
  chk_latch_oe: assert property ($rose(module_pin_out) |-> !module_pin_oe_n)
    else $error("latch set while pin not driven");
endmodule : ccpcu_props

// [tb/ccpcu_capture_compare_unit_bench.sv]
// Self-checking bench for the capture/compare unit over its register bus.
module ccpcu_capture_compare_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [4:0] npul = 5'h0;
  ccpcu_pkg::ccpcu_timebase_t timebase = '0;
  ccpcu_pkg::ccpcu_trigger_t trigger;
  logic hreadyout, hresp, module_pin_out, module_pin_oe_n, unit_event_flag;
  logic timebase_overflow_block, src_pin, busy;
  int miscompares = 0, samples_checked = 0, n_adc = 0, n_rst = 0;
  // The pin wire follows the unit while it drives and the source otherwise.
  wire module_pin_in = module_pin_oe_n ? src_pin : module_pin_out;
  ccpcu_capture_compare_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .module_pin_in, .timebase, .trigger, .module_pin_out, .module_pin_oe_n,
    .unit_event_flag, .timebase_overflow_block);
  ccpcu_pin_source src (.hclk, .hresetn, .go, .npul, .pin(src_pin), .busy);
  initial forever #20 hclk = ~hclk;
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
  end
  // Trigger pulses are totalled so scenarios compare counts, not instants.
  always @(posedge hclk) begin
    if (trigger.adc_start === 1'b1) n_adc++;
    if (trigger.timebase_reset === 1'b1) n_rst++;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= ccpcu_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(exp, rd);
  endtask : rdc
  task automatic pulses(input logic [4:0] n);
    go <= 1'b1;
    npul <= n;
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (busy === 1'b1);
    repeat (5) @(posedge hclk);
  endtask : pulses
  task automatic match(input logic [31:0] m);
    timebase.count <= 16'h0;
    bus(1'b1, 8'h00, m);
    bus(1'b1, 8'h0C, 32'h0);
    timebase.count <= 16'h1234;
    repeat (4) @(posedge hclk);
  endtask : match
  task automatic tick();
    timebase.tick <= 1'b1;
    @(posedge hclk);
    timebase.tick <= 1'b0;
    timebase.count <= 16'h0;
    repeat (3) @(posedge hclk);
  endtask : tick
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // The tests need a few hundred cycles; this limit is generous.
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    @(posedge hresetn);
    @(posedge hclk);
    rdc(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'hFF);
    rdc(8'h00, 32'h3F);
    rdc(8'h14, 32'h0);
    // Two edges per mode: the second capture must overwrite the first.
    for (logic [31:0] m = 32'h4; m < 32'h6; m++) begin
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, m);
      bus(1'b1, 8'h0C, 32'h0);
      timebase.count <= 16'hA5C0;
      pulses(5'h1);
      timebase.count <= {8'h3E, m[7:0]};
      pulses(5'h1);
      rdc(8'h04, m);
      rdc(8'h08, 32'h3E);
      cmp(32'h1, unit_event_flag);
    end
    // Partial counts are discarded by switching off before the real burst.
    for (logic [31:0] m = 32'h6; m < 32'h8; m++) begin
      bus(1'b1, 8'h00, m);
      pulses(5'h2);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, m);
      bus(1'b1, 8'h0C, 32'h0);
      timebase.count <= {8'h7A, m[7:0]};
      pulses((m == 32'h6) ? 5'h3 : 5'hF);
      cmp(32'h0, unit_event_flag);
      pulses(5'h1);
      cmp(32'h1, unit_event_flag);
      rdc(8'h04, m);
    end
    bus(1'b1, 8'h04, 32'h34);
    bus(1'b1, 8'h08, 32'h12);
    for (logic [31:0] m = 32'h8; m < 32'hB; m++) begin
      match(m);
      cmp(32'h1, unit_event_flag);
      cmp({31'h0, m == 32'hA}, module_pin_oe_n);
      cmp({31'h0, m == 32'h8}, module_pin_out);
      bus(1'b1, 8'h0C, 32'h0);
      repeat (3) @(posedge hclk);
      cmp(32'h0, unit_event_flag);
    end
    match(32'h8);
    rdc(8'h0C, 32'h3);
    bus(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge hclk);
    rdc(8'h0C, 32'h1);
    bus(1'b1, 8'h10, 32'h1);
    match(32'hB);
    tick();
    cmp(32'h1, n_adc);
    cmp(32'h1, n_rst);
    timebase.count <= 16'h1234;
    repeat (3) @(posedge hclk);
    bus(1'b1, 8'h04, 32'h35);
    tick();
    cmp(32'h2, n_adc);
    cmp(32'h1, n_rst);
    summarize();
  end
endmodule : ccpcu_capture_compare_unit_bench
bind ccpcu_capture_compare_unit ccpcu_props chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .timebase, .trigger, .module_pin_out,
  .module_pin_oe_n, .unit_event_flag, .timebase_overflow_block);
